// *** pkg/ldl_pkg.sv ***
// Constants shared by the serial data-load latch block.
// Assumes a single mclk domain; all pins are sampled by the block itself.
package ldl_pkg;
   // ======================================================
   // Latch geometry
   localparam int LDL_SHIFT_W = 769;
   localparam int LDL_INTEN_W = 768;
   localparam int LDL_CTRL_W = 371;
   localparam int LDL_TRIM_W = 336;
   localparam int LDL_CODE_W = 7;
   // ======================================================
   // Routing of a loaded word
   localparam int LDL_SEL_HI = 767;
   localparam int LDL_SEL_LO = 760;
   localparam logic [7:0] LDL_SELECTOR = 8'h96;
   // ======================================================
   // Control latch fields
   localparam int LDL_DEFER_BIT = 368;
   localparam int LDL_RESTART_BIT = 367;
   localparam int LDL_PEAK_LO = 336;
   localparam int LDL_PEAK_HI = 344;
   localparam int LDL_PEAK_W = 9;
   localparam logic [8:0] LDL_PEAK_RST = 9'h000;
   // ======================================================
   // Timing counts and link buffering
   localparam int LDL_PWM_W = 16;
   localparam int LDL_DEFER_COUNT = 65536;
   localparam int LDL_DEFER_W = 17;
   localparam int LDL_FIFO_DEPTH = 32;
   localparam int LDL_FIFO_W = 2;
   localparam int LDL_NPINS = 4;
   // Pin slots in the synchroniser vector
   localparam int LDL_PIN_SIN = 0;
   localparam int LDL_PIN_SCK = 1;
   localparam int LDL_PIN_LAT = 2;
   localparam int LDL_PIN_PWM = 3;
endpackage

// *** rtl/ldl_fifo.sv ***
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes a single clock; ready and valid are read by same-domain logic.
module ldl_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic ready_reg;
   logic push;
   logic pop;

   // ======================================================
   // Handshake terms
   assign push = in_valid && ready_reg;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign in_ready = ready_reg;

   // Fill level after this cycle's push and pop
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers, level and registered ready
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         ready_reg <= (count_next != FULL_COUNT);
      end
   end
endmodule // ldl_fifo

// *** rtl/ldl_latches.sv ***
// Serial load path of a 48-channel LED sink driver: shift register,
// intensity latch, control latch and trim latch.
// Assumes pins arrive asynchronously and are slow against mclk.
module ldl_latches
   import ldl_pkg::*;
#(
   parameter int DEFER_COUNT = LDL_DEFER_COUNT,
   parameter int FIFO_DEPTH = LDL_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic serial_in_pin,
   input wire logic shift_clock,
   input wire logic load_strobe,
   input wire logic pwm_count_clock,
   output logic serial_out_pin,
   output logic link_ready,
   output logic [LDL_INTEN_W-1:0] pixel_intensity,
   output logic [LDL_CTRL_W-1:0] control_latch,
   output logic [LDL_TRIM_W-1:0] channel_current_trim,
   output logic [LDL_PEAK_W-1:0] peak_current_select,
   output logic [LDL_PWM_W-1:0] pwm_count,
   output logic sink_enable
);
   localparam logic [LDL_DEFER_W-1:0] DEFER_LAST =
      LDL_DEFER_W'(DEFER_COUNT - 1);

   // ======================================================
   // Pin synchronisers and edge detection
   logic [LDL_NPINS-1:0] pin_raw;
   logic [LDL_NPINS-1:0] pin_meta_reg;
   logic [LDL_NPINS-1:0] pin_sync_reg;
   logic [LDL_NPINS-1:0] pin_prev_reg;
   logic shift_edge;
   logic strobe_edge;
   logic pwm_edge;

   assign pin_raw = {pwm_count_clock, load_strobe, shift_clock,
                     serial_in_pin};

   // Two stages, then a history stage for edge finding
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // Rising edges of the sampled clocks and strobe
   assign shift_edge = pin_sync_reg[LDL_PIN_SCK] && !pin_prev_reg[LDL_PIN_SCK];
   assign strobe_edge = pin_sync_reg[LDL_PIN_LAT] &&
                        !pin_prev_reg[LDL_PIN_LAT];
   assign pwm_edge = pin_sync_reg[LDL_PIN_PWM] && !pin_prev_reg[LDL_PIN_PWM];

   // ======================================================
   // Event buffer: bit 1 marks a strobe, bit 0 carries the data bit
   logic [LDL_FIFO_W-1:0] ev_in;
   logic ev_in_valid;
   logic [LDL_FIFO_W-1:0] ev_out;
   logic ev_out_valid;
   logic ev_out_ready;
   logic ev_pop;
   logic ev_is_strobe;
   logic do_shift;
   logic do_strobe;

   // A strobe edge outranks a simultaneous shift edge
   always_comb begin
      ev_in = {1'b0, pin_sync_reg[LDL_PIN_SIN]};
      if (strobe_edge) begin
         ev_in = {1'b1, 1'b0};
      end
   end
   assign ev_in_valid = shift_edge || strobe_edge;

   ldl_fifo #(
      .WIDTH(LDL_FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rstn(rstn),
      .in_data(ev_in),
      .in_valid(ev_in_valid),
      .in_ready(link_ready),
      .out_data(ev_out),
      .out_valid(ev_out_valid),
      .out_ready(ev_out_ready)
   );

   // ======================================================
   // Shift register
   logic [LDL_SHIFT_W-1:0] shift_reg;
   logic defer_busy_reg;

   // A strobe waits while a deferred update is still pending
   assign ev_is_strobe = ev_out[1];
   assign ev_out_ready = !(ev_is_strobe && defer_busy_reg);
   assign ev_pop = ev_out_valid && ev_out_ready;
   assign do_shift = ev_pop && !ev_is_strobe;
   assign do_strobe = ev_pop && ev_is_strobe;

   // Serial bits enter at bit 0 and walk upward
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shift_reg <= '0;
      end else if (do_shift) begin
         shift_reg <= {shift_reg[LDL_SHIFT_W-2:0], ev_out[0]};
      end
   end

   // Top bit goes straight out for daisy chaining
   assign serial_out_pin = shift_reg[LDL_SHIFT_W-1];

   // ======================================================
   // Routing of a strobe by the word's top bit and selector
   logic inten_write;
   logic ctrl_write;
   logic [LDL_CTRL_W-1:0] ctrl_reg;
   logic defer_on;
   logic restart_on;

   assign inten_write = do_strobe && !shift_reg[LDL_SHIFT_W-1];
   assign ctrl_write = do_strobe && shift_reg[LDL_SHIFT_W-1] &&
      (shift_reg[LDL_SEL_HI:LDL_SEL_LO] == LDL_SELECTOR);
   assign defer_on = ctrl_reg[LDL_DEFER_BIT];
   assign restart_on = ctrl_reg[LDL_RESTART_BIT];

   // Control latch; power-up contents modelled as zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= '0;
      end else if (ctrl_write) begin
         ctrl_reg <= shift_reg[LDL_CTRL_W-1:0];
      end
   end
   assign control_latch = ctrl_reg;

   // ======================================================
   // Peak-current fields, double-write protected
   logic [LDL_PEAK_W-1:0] peak_reg;
   logic [LDL_PEAK_W-1:0] peak_prev_reg;
   logic peak_prev_valid_reg;
   logic [LDL_PEAK_W-1:0] peak_new;

   assign peak_new = shift_reg[LDL_PEAK_HI:LDL_PEAK_LO];

   // Change only when two back-to-back control writes agree
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         peak_reg <= LDL_PEAK_RST;
         peak_prev_reg <= LDL_PEAK_RST;
         peak_prev_valid_reg <= 1'b0;
      end else if (ctrl_write) begin
         if (peak_prev_valid_reg && peak_prev_reg == peak_new) begin
            peak_reg <= peak_new;
         end
         peak_prev_reg <= peak_new;
         peak_prev_valid_reg <= 1'b1;
      end
   end
   assign peak_current_select = peak_reg;

   // ======================================================
   // Deferred update: holds the word and counts PWM clocks
   logic [LDL_INTEN_W-1:0] pending_reg;
   logic [LDL_DEFER_W-1:0] defer_cnt_reg;
   logic defer_commit;

   assign defer_commit = defer_busy_reg && pwm_edge &&
                         (defer_cnt_reg == DEFER_LAST);

   // Arm on an intensity strobe in deferred mode, fire on last PWM clock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         defer_busy_reg <= 1'b0;
         defer_cnt_reg <= '0;
         pending_reg <= '0;
      end else if (inten_write && defer_on) begin
         defer_busy_reg <= 1'b1;
         defer_cnt_reg <= '0;
         pending_reg <= shift_reg[LDL_INTEN_W-1:0];
      end else if (defer_commit) begin
         defer_busy_reg <= 1'b0;
         defer_cnt_reg <= '0;
      end else if (defer_busy_reg && pwm_edge) begin
         defer_cnt_reg <= defer_cnt_reg + 1'b1;
      end
   end

   // ======================================================
   // Intensity and trim latches
   logic [LDL_INTEN_W-1:0] inten_reg;
   logic [LDL_TRIM_W-1:0] trim_reg;
   logic written_reg;

   // Immediate copy at the strobe, or the held word at commit
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         inten_reg <= '0;
         trim_reg <= '0;
         written_reg <= 1'b0;
      end else if (inten_write && !defer_on) begin
         inten_reg <= shift_reg[LDL_INTEN_W-1:0];
         trim_reg <= ctrl_reg[LDL_TRIM_W-1:0];
         written_reg <= 1'b1;
      end else if (defer_commit) begin
         inten_reg <= pending_reg;
         trim_reg <= ctrl_reg[LDL_TRIM_W-1:0];
         written_reg <= 1'b1;
      end
   end
   assign pixel_intensity = inten_reg;
   assign channel_current_trim = trim_reg;

   // ======================================================
   // PWM counter with synchronous restart
   logic [LDL_PWM_W-1:0] pwm_cnt_reg;
   logic forced_off_reg;
   logic sink_en_reg;

   // Restart wins over a PWM clock in the same cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pwm_cnt_reg <= '0;
         forced_off_reg <= 1'b0;
      end else if (inten_write && restart_on) begin
         pwm_cnt_reg <= '0;
         forced_off_reg <= 1'b1;
      end else if (pwm_edge) begin
         pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
         forced_off_reg <= 1'b0;
      end
   end
   assign pwm_count = pwm_cnt_reg;

   // Outputs allowed only after first intensity write and no restart
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sink_en_reg <= 1'b0;
      end else begin
         sink_en_reg <= written_reg && !forced_off_reg &&
                        !(inten_write && restart_on);
      end
   end
   assign sink_enable = sink_en_reg;
endmodule // ldl_latches

// *** bench/ldl_latches_properties.sv ***
// Assertions on the serial load latch block, bound to its top module.
// Assumes pins change just after a rising mclk edge.
module ldl_latches_properties
   import ldl_pkg::*;
#(
   parameter int DEFER_COUNT = LDL_DEFER_COUNT,
   parameter int FIFO_DEPTH = LDL_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic serial_in_pin,
   input wire logic shift_clock,
   input wire logic load_strobe,
   input wire logic pwm_count_clock,
   input wire logic serial_out_pin,
   input wire logic link_ready,
   input wire logic [LDL_INTEN_W-1:0] pixel_intensity,
   input wire logic [LDL_CTRL_W-1:0] control_latch,
   input wire logic [LDL_TRIM_W-1:0] channel_current_trim,
   input wire logic [LDL_PEAK_W-1:0] peak_current_select,
   input wire logic [LDL_PWM_W-1:0] pwm_count,
   input wire logic sink_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] sck_age, lat_age, pwm_age;
   logic sck_prev_reg, pwm_prev_reg;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   function automatic logic [5:0] inc(input logic [5:0] a);
      return (a == 6'h3F) ? a : a + 6'h01;
   endfunction
   // ==========
   // Cycles since each pin last rose or was high
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sck_prev_reg <= 1'b0;
         pwm_prev_reg <= 1'b0;
         sck_age <= 6'h3F;
         lat_age <= 6'h3F;
         pwm_age <= 6'h3F;
      end else begin
         sck_prev_reg <= shift_clock;
         pwm_prev_reg <= pwm_count_clock;
         sck_age <= (shift_clock && !sck_prev_reg) ? 6'h00 : inc(sck_age);
         lat_age <= load_strobe ? 6'h00 : inc(lat_age);
         pwm_age <= (pwm_count_clock && !pwm_prev_reg) ? 6'h00 :
                    inc(pwm_age);
      end
   end
   // ==========
   // Checks
   property p_serial_out_pin;
      $changed(serial_out_pin) |-> sck_age inside {[2:6]} ||
         (pwm_age < 60 && control_latch[LDL_DEFER_BIT]);
   endproperty
   a_serial_out_pin: assert property (p_serial_out_pin)
      else $error("serial out moved without shift");
   property p_ctrl;
      $changed(control_latch) |-> lat_age < 8;
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("control latch moved without strobe");
   property p_inten;
      $changed(pixel_intensity) |->
         (control_latch[LDL_DEFER_BIT] ? pwm_age < 8 : lat_age < 8);
   endproperty
   a_inten: assert property (p_inten)
      else $error("intensity moved at wrong time");
   property p_trim;
      $changed(channel_current_trim) |->
         channel_current_trim == control_latch[LDL_TRIM_W-1:0] &&
         (control_latch[LDL_DEFER_BIT] ? pwm_age < 8 : lat_age < 8);
   endproperty
   a_trim: assert property (p_trim)
      else $error("trim copy wrong");
   property p_peak;
      $changed(peak_current_select) |-> lat_age < 8 &&
         peak_current_select == control_latch[LDL_PEAK_HI:LDL_PEAK_LO];
   endproperty
   a_peak: assert property (p_peak)
      else $error("peak codes wrong");
   property p_pwm;
      $changed(pwm_count) |->
         (pwm_count == $past(pwm_count) + 16'h0001 && pwm_age < 8) ||
         (pwm_count == 16'h0000 && control_latch[LDL_RESTART_BIT]);
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("pwm count step wrong");
   property p_restart;
      $fell(sink_enable) |->
         control_latch[LDL_RESTART_BIT] && pwm_count == 16'h0000;
   endproperty
   a_restart: assert property (p_restart)
      else $error("outputs forced off without restart");
   property p_sink_on;
      $rose(sink_enable) |-> lat_age < 9 || pwm_age < 8;
   endproperty
   a_sink_on: assert property (p_sink_on)
      else $error("outputs enabled without cause");
endmodule // ldl_latches_properties

bind ldl_latches ldl_latches_properties #(.DEFER_COUNT(DEFER_COUNT),
   .FIFO_DEPTH(FIFO_DEPTH)) chk_u (.mclk(mclk), .rstn(rstn),
   .serial_in_pin(serial_in_pin), .shift_clock(shift_clock),
   .load_strobe(load_strobe), .pwm_count_clock(pwm_count_clock),
   .serial_out_pin(serial_out_pin), .link_ready(link_ready),
   .pixel_intensity(pixel_intensity), .control_latch(control_latch),
   .channel_current_trim(channel_current_trim),
   .peak_current_select(peak_current_select), .pwm_count(pwm_count),
   .sink_enable(sink_enable));

// *** bench/ldl_ctrl_model.sv ***
// Display controller model: shift clock, serial data, strobe, pwm clock.
// Assumes the caller uses its tasks one at a time.
module ldl_ctrl_model (
   input wire logic mclk,
   output logic serial_in_pin,
   output logic shift_clock,
   output logic load_strobe,
   output logic pwm_count_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle pins at time zero
   initial begin
      serial_in_pin = 1'b0;
      shift_clock = 1'b0;
      load_strobe = 1'b0;
      pwm_count_clock = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Shift n bits top first, 80 ns per bit, clock still after
   task automatic send(input logic [768:0] w, input int n);
      for (int i = 768; i > 768 - n; i--) begin
         serial_in_pin = w[i];
         tick(5);
         shift_clock = 1'b1;
         tick(5);
         shift_clock = 1'b0;
      end
      serial_in_pin = ~serial_in_pin; // No stale bit on idle line
   endtask
   task automatic strobe();
      load_strobe = 1'b1;
      tick(5);
      load_strobe = 1'b0;
      tick(5);
   endtask
   task automatic pwm(input int n);
      repeat (n) begin
         pwm_count_clock = 1'b1;
         tick(3);
         pwm_count_clock = 1'b0;
         tick(3);
      end
   endtask
endmodule // ldl_ctrl_model

// *** bench/tb_led_driver_serial_data_latches.sv ***
// Testbench for the serial load latch block with a controller model.
// Assumes the checker binds itself to the block.
module tb_led_driver_serial_data_latches
   import ldl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEFER = 8;
   logic mclk, rstn, serial_in_pin, shift_clock, load_strobe;
   logic pwm_count_clock, serial_out_pin, link_ready, sink_enable;
   logic [LDL_INTEN_W-1:0] pixel_intensity;
   logic [LDL_CTRL_W-1:0] control_latch;
   logic [LDL_TRIM_W-1:0] channel_current_trim;
   logic [LDL_PEAK_W-1:0] peak_current_select;
   logic [LDL_PWM_W-1:0] pwm_count;
   logic [768:0] w, inten1, inten2;
   logic full_seen;
   int err_total, total_checks, cyc;
   ldl_latches #(.DEFER_COUNT(DEFER), .FIFO_DEPTH(LDL_FIFO_DEPTH)) dut_u (
      .mclk(mclk), .rstn(rstn), .serial_in_pin(serial_in_pin),
      .shift_clock(shift_clock), .load_strobe(load_strobe),
      .pwm_count_clock(pwm_count_clock), .serial_out_pin(serial_out_pin),
      .link_ready(link_ready), .pixel_intensity(pixel_intensity),
      .control_latch(control_latch),
      .channel_current_trim(channel_current_trim),
      .peak_current_select(peak_current_select), .pwm_count(pwm_count),
      .sink_enable(sink_enable));
   ldl_ctrl_model ctl_u (.mclk(mclk), .serial_in_pin(serial_in_pin),
      .shift_clock(shift_clock), .load_strobe(load_strobe),
      .pwm_count_clock(pwm_count_clock));
   // ==========
   // Clock, cycle ceiling and full buffer watch
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rstn && link_ready === 1'b0)
         full_seen <= 1'b1;
      if (cyc == 90000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [767:0] seen, input logic [767:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [768:0] mk(input logic d, input logic r,
                                       input logic [6:0] t);
      return {1'b1, LDL_SELECTOR, 389'h0, 2'b00, d, r, 22'h2AB3C5, 9'h0D1,
              {48{t}}};
   endfunction
   // ==========
   // Main sequence
   initial begin
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      full_seen = 1'b0;
      rstn = 1'b0;
      inten1 = {1'b0, {12{64'h0123456789ABCDEF}}};
      inten2 = {1'b0, ~inten1[767:0]};
      repeat (4) @(posedge mclk);
      #1 rstn = 1'b1;
      ctl_u.tick(2);
      ctl_u.pwm(5);
      chk(768'(pwm_count), 768'(16'h0005));
      chk(768'(peak_current_select), 768'(LDL_PEAK_RST));
      chk(768'(sink_enable), 768'(1'b0));
      // Two identical control writes commit the peak codes
      w = mk(1'b0, 1'b0, 7'h7F);
      repeat (2) begin
         chk(768'(peak_current_select), 768'(LDL_PEAK_RST));
         ctl_u.send(w, 769);
         ctl_u.strobe();
         chk(768'(control_latch), 768'(w[370:0]));
      end
      chk(768'(peak_current_select), 768'(w[344:336]));
      chk(768'(serial_out_pin), 768'(w[768]));
      // Plain intensity write copies trim at the strobe
      ctl_u.send(inten1, 769);
      ctl_u.strobe();
      chk(pixel_intensity, inten1[767:0]);
      chk(768'(channel_current_trim), 768'({48{7'h7F}}));
      chk(768'(sink_enable), 768'(1'b1));
      chk(768'(serial_out_pin), 768'(1'b0));
      // Wrong selector touches no latch
      ctl_u.send({1'b1, 8'h95, inten2[759:0]}, 769);
      ctl_u.strobe();
      chk(pixel_intensity, inten1[767:0]);
      chk(768'(control_latch), 768'(w[370:0]));
      // Deferred update with timing restart
      w = mk(1'b1, 1'b1, 7'h15);
      ctl_u.send(w, 769);
      ctl_u.strobe();
      chk(768'(channel_current_trim), 768'({48{7'h7F}}));
      ctl_u.send(inten2, 769);
      ctl_u.strobe();
      chk(768'(pwm_count), 768'(16'h0000));
      chk(768'(sink_enable), 768'(1'b0));
      ctl_u.pwm(1);
      chk(768'(sink_enable), 768'(1'b1));
      chk(768'(pwm_count), 768'(16'h0001));
      ctl_u.pwm(DEFER - 2);
      chk(pixel_intensity, inten1[767:0]);
      ctl_u.pwm(1);
      chk(pixel_intensity, inten2[767:0]);
      chk(768'(channel_current_trim), 768'({48{7'h15}}));
      // Strobe held back by a pending update fills the buffer
      full_seen = 1'b0;
      ctl_u.strobe();
      ctl_u.strobe();
      ctl_u.send(inten1, 40);
      chk(768'(full_seen), 768'(1'b1));
      ctl_u.pwm(DEFER);
      ctl_u.tick(40);
      chk(768'(link_ready), 768'(1'b1));
      report_and_stop();
   end
endmodule // tb_led_driver_serial_data_latches
